/* apwm_defs.svh */
`ifndef APWM_DEFS_SVH
`define APWM_DEFS_SVH

// register word byte addresses
`define APWM_ADDR_CTRL0 8'h00
`define APWM_ADDR_CTRL1 8'h04
`define APWM_ADDR_PERIOD 8'h08
`define APWM_ADDR_DUTY1 8'h0c
`define APWM_ADDR_DUTY2 8'h10
`define APWM_ADDR_SAMPLE 8'h14
`define APWM_ADDR_STATUS 8'h18
`define APWM_ADDR_MASK 8'h1c
`define APWM_ADDR_COUNT 8'h20

// timer_control_zero fields
`define APWM_C0_RUN 3
`define APWM_C0_CKS_LSB 4
`define APWM_C0_AUDIO 0
`define APWM_C0_STYLE 1
// timer_control_one fields
`define APWM_C1_MODE_LSB 6
`define APWM_C1_OUT_LSB 4
`define APWM_C1_ACTIVE 3
`define APWM_C1_INVERT 2
`define APWM_C1_SWAP 0

// clock select, mode and output codes
`define APWM_CKS_QUARTER 3'h0
`define APWM_CKS_SYS 3'h1
`define APWM_CKS_HIGH 3'h5
`define APWM_MODE_PWM 2'h2
`define APWM_OUT_PWM 2'h2
`define APWM_OUT_LOW 2'h0
`define APWM_OUT_HIGH 2'h1

// reset values and the quarter-rate divider tick value
`define APWM_RST_C0 8'h00
`define APWM_RST_C1 8'h00
`define APWM_RST_PERIOD 10'h000
`define APWM_QUARTER_DIV 2'h3

// status bits: period match, duty one match, duty two match
`define APWM_ST_PERIOD 0
`define APWM_ST_DUTY1 1
`define APWM_ST_DUTY2 2

`endif

/* apwm_pkg.sv */
package apwm_pkg;
	typedef struct packed {
		logic [2:0] clk_sel;
		logic run;
		logic unused;
		logic style_single;
		logic audio_sel;
		logic [0:0] pad;
	} apwm_ctrl0_type;

	typedef struct packed {
		logic [7:0] duty_one;
		logic [7:0] duty_two;
	} apwm_duty_pair_type;

	typedef struct packed {
		logic out_one;
		logic out_two;
	} apwm_pins_type;

	typedef enum logic [1:0] {
		APWM_IDLE = 2'b00,
		APWM_ACK = 2'b01,
		APWM_DONE = 2'b11
	} apwm_bus_state_type;
endpackage

/* apwm_pcm_convert.sv */
`timescale 1ns/10ps
`include "apwm_defs.svh"

// maps a 16-bit unsigned pcm sample to the two duty values
module apwm_pcm_convert (
	input wire logic [15:0] sample_i,
	input wire logic single_i,
	output apwm_pkg::apwm_duty_pair_type duty_o
);
	import apwm_pkg::*;

	logic [15:0] pcm_sample_inverted;

	assign pcm_sample_inverted = ~sample_i;

	// conversion is pure logic; the caller registers the result
	always_comb begin
		if (!single_i) begin
			duty_o.duty_one = sample_i[15:8];
			duty_o.duty_two = pcm_sample_inverted[15:8];
		end else if (!sample_i[15]) begin
			duty_o.duty_one = 8'h00;
			duty_o.duty_two = pcm_sample_inverted[14:7];
		end else begin
			duty_o.duty_one = sample_i[14:7];
			duty_o.duty_two = 8'h00;
		end
	end
endmodule

/* apwm_player.sv */
// Implementation choices: the register offsets and register access over Wishbone.
`timescale 1ns/10ps
`include "apwm_defs.svh"

// Summary of operation
// - codes 001/101 count at clock rate
// - code 000 counts at quarter clock
// - audio-select bit enables audio pwm mode
// - mode and output fields set to PWM
// - active-level one, invert zero: active high
// - period 256 gives clock over 256
// - run bit starts counter last
// - accepts 16-bit unsigned pcm samples
// - differential or single-ended output styles
// - differential duty one gets bits 15:8
// - differential duty two gets complement
// - single, sign zero: two gets ~14:7
// - single, sign one: one gets 14:7
// - duty equals register over 256
// - period and duties shadowed until overflow
// - period clears counter, duties set outputs
// - swap bit forced zero in audio
module apwm_player (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [15:0] pcm_data_i,
	input wire logic pcm_valid_i,
	output logic pcm_ready_o,
	output apwm_pkg::apwm_pins_type pwm_o,
	output logic irq_o
);
	import apwm_pkg::*;

	logic [7:0] ctrl0_q;
	logic [7:0] ctrl1_q;
	logic [9:0] period_q;
	logic [9:0] period_act_q;
	logic [7:0] duty1_q;
	logic [7:0] duty2_q;
	logic [7:0] duty1_act_q;
	logic [7:0] duty2_act_q;
	logic [9:0] count_q;
	logic [1:0] div_q;
	logic [2:0] status_q;
	logic [2:0] mask_q;
	logic [15:0] sample_q;
	logic ack_q;
	logic run_q;
	apwm_pins_type pins_q;
	apwm_duty_pair_type conv_duty;
	logic tick;
	logic wr_en;
	logic period_hit;
	logic audio_on;
	logic [2:0] ev;
	logic [9:0] period_len;
	logic [31:0] rd_data;
	logic pcm_take;
	logic [1:0] below;
	logic [1:0] level;

	// one-word register decode shared by the write and ready paths; the read mux decodes by case
	function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
		hit = (adr == off);
	endfunction

	assign audio_on = ctrl0_q[`APWM_C0_AUDIO];
	// byte lane 0 enables every register write; lane 1 adds only the period top bits
	assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q && wb_sel_i[0];

	// single wait-free answer: ack the cycle after strobe, drop after
	// the ack cycle itself blocks a new take, so a request dropped the cycle after ack is taken once
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
		end
	end
	assign wb_ack_o = ack_q;

	// control register zero: audio select, style, run and clock code
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl0_q <= `APWM_RST_C0;
		end else if (wr_en && hit(wb_adr_i, `APWM_ADDR_CTRL0)) begin
			ctrl0_q <= wb_dat_i[7:0];
		end
	end

	// control register one: mode, output field, level, inversion, swap
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl1_q <= `APWM_RST_C1;
		end else if (wr_en && hit(wb_adr_i, `APWM_ADDR_CTRL1)) begin
			ctrl1_q <= wb_dat_i[7:0];
		end
	end

	// bus writes win; the stream waits a cycle rather than lose a write
	assign pcm_ready_o = !(wr_en && (hit(wb_adr_i, `APWM_ADDR_PERIOD) ||
		hit(wb_adr_i, `APWM_ADDR_DUTY1) || hit(wb_adr_i, `APWM_ADDR_DUTY2)));
	// a sample is taken only in a cycle with no shadow write
	assign pcm_take = pcm_valid_i && pcm_ready_o;

	// period shadow (software side); lane 1 carries the top two bits
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			period_q <= `APWM_RST_PERIOD;
		end else if (wr_en && hit(wb_adr_i, `APWM_ADDR_PERIOD)) begin
			period_q <= {wb_sel_i[1] ? wb_dat_i[9:8] : period_q[9:8], wb_dat_i[7:0]};
		end
	end

	// duty one shadow: loaded by the bus or by a converted sample
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			duty1_q <= 8'h00;
		end else if (wr_en && hit(wb_adr_i, `APWM_ADDR_DUTY1)) begin
			duty1_q <= wb_dat_i[7:0];
		end else if (pcm_take) begin
			duty1_q <= conv_duty.duty_one;
		end
	end

	// duty two shadow: loaded by the bus or by a converted sample
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			duty2_q <= 8'h00;
		end else if (wr_en && hit(wb_adr_i, `APWM_ADDR_DUTY2)) begin
			duty2_q <= wb_dat_i[7:0];
		end else if (pcm_take) begin
			duty2_q <= conv_duty.duty_two;
		end
	end

	// last sample kept for read-back only; it never drives the pins itself
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sample_q <= 16'h0000;
		end else if (pcm_take) begin
			// stream sample converted into both duties
			sample_q <= pcm_data_i;
		end
	end

	// style bit picks differential or single
	apwm_pcm_convert u_conv (
		.sample_i(pcm_data_i),
		.single_i(ctrl0_q[`APWM_C0_STYLE]),
		.duty_o(conv_duty)
	);

	// held at zero while stopped so every start has the same phase
	// quarter-rate enable from a divider
	always_ff @(posedge clk_i) begin
		if (rst_i || !run_q) begin
			div_q <= 2'h0;
		end else begin
			div_q <= div_q + 2'h1;
		end
	end
	always_comb begin
		case (ctrl0_q[`APWM_C0_CKS_LSB +: 3])
			`APWM_CKS_SYS: tick = 1'b1;
			`APWM_CKS_HIGH: tick = 1'b1;
			`APWM_CKS_QUARTER: tick = (div_q == `APWM_QUARTER_DIV);
			default: tick = 1'b1;
		endcase
	end

	// clearing run stops the count and lets the active registers follow
	// run bit gates the counter
	assign run_q = ctrl0_q[`APWM_C0_RUN];

	// period zero counts as full 1024-count span
	assign period_len = period_act_q;
	assign period_hit = tick && (count_q == period_len - 10'h001);

	// period counter; cleared at the match, so a period of n gives n counts
	always_ff @(posedge clk_i) begin
		if (rst_i || !run_q) begin
			count_q <= 10'h000;
		end else if (period_hit) begin
			count_q <= 10'h000;
		end else if (tick) begin
			count_q <= count_q + 10'h001;
		end
	end

	// shadow values applied while stopped, and at overflow in audio mode
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			period_act_q <= `APWM_RST_PERIOD;
			duty1_act_q <= 8'h00;
			duty2_act_q <= 8'h00;
		end else if (!run_q || (period_hit && audio_on)) begin
			period_act_q <= period_q;
			duty1_act_q <= duty1_q;
			duty2_act_q <= duty2_q;
		end
	end

	// both outputs share the one period counter; a generate loop keeps the
	// two compare paths identical by construction
	for (genvar g = 0; g < 2; g++) begin
		logic [7:0] duty_sel;
		// index 0 feeds output one, index 1 output two
		assign duty_sel = (g == 0) ? duty1_act_q : duty2_act_q;
		assign below[g] = count_q < {2'b00, duty_sel};
		assign level[g] = (below[g] ~^ ctrl1_q[`APWM_C1_ACTIVE]) ^ ctrl1_q[`APWM_C1_INVERT];
	end

	// pins are registered so they never glitch on a compare edge; the price
	// is one clock of lag behind the counter, the same for both outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pins_q <= '0;
		end else if (!(audio_on && ctrl1_q[`APWM_C1_MODE_LSB +: 2] == `APWM_MODE_PWM)) begin
			pins_q <= '0;
		end else begin
			// output field selects pwm or forced level
			case (ctrl1_q[`APWM_C1_OUT_LSB +: 2])
				`APWM_OUT_PWM: begin
					pins_q.out_one <= level[0];
					pins_q.out_two <= level[1];
				end
				`APWM_OUT_HIGH: pins_q <= 2'b11;
				`APWM_OUT_LOW: pins_q <= 2'b00;
				default: pins_q <= pins_q;
			endcase
		end
	end
	assign pwm_o = pins_q;

	// events: period match, duty one match, duty two match
	// a duty event fires once per period when the duty is below the period, at the count equal to the duty
	assign ev[`APWM_ST_PERIOD] = period_hit;
	assign ev[`APWM_ST_DUTY1] = tick && run_q && (count_q == {2'b00, duty1_act_q});
	assign ev[`APWM_ST_DUTY2] = tick && run_q && (count_q == {2'b00, duty2_act_q});

	// sticky status; a new event wins over a write-one clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status_q <= 3'h0;
		end else begin
			status_q <= (status_q & ~((wr_en && hit(wb_adr_i, `APWM_ADDR_STATUS)) ?
				wb_dat_i[2:0] : 3'h0)) | ev;
		end
	end
	// mask register, same layout as status
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mask_q <= 3'h0;
		end else if (wr_en && hit(wb_adr_i, `APWM_ADDR_MASK)) begin
			mask_q <= wb_dat_i[2:0];
		end
	end
	// level interrupt: high while any unmasked status bit stays set
	assign irq_o = |(status_q & mask_q);

	// read mux; unmapped addresses read zero
	always_comb begin
		rd_data = 32'h0000_0000;
		case (wb_adr_i)
			`APWM_ADDR_CTRL0: rd_data = {24'h0, ctrl0_q};
			// swap bit reads zero in audio mode
			`APWM_ADDR_CTRL1: rd_data = {24'h0, ctrl1_q[7:1],
				ctrl1_q[`APWM_C1_SWAP] & ~audio_on};
			`APWM_ADDR_PERIOD: rd_data = {22'h0, period_q};
			`APWM_ADDR_DUTY1: rd_data = {24'h0, duty1_q};
			`APWM_ADDR_DUTY2: rd_data = {24'h0, duty2_q};
			`APWM_ADDR_SAMPLE: rd_data = {16'h0, sample_q};
			`APWM_ADDR_STATUS: rd_data = {29'h0, status_q};
			`APWM_ADDR_MASK: rd_data = {29'h0, mask_q};
			`APWM_ADDR_COUNT: rd_data = {22'h0, count_q};
			default: rd_data = 32'h0000_0000;
		endcase
	end
	// read data registered: it stands in the ack cycle because the master
	// holds the address until it has seen ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_dat_o <= rd_data;
		end
	end
	// pins always driven; routing is software's
endmodule

/* apwm_spk.sv */
`timescale 1ns/10ps

// speaker load: integrates each pin's high time so a window gives its duty
module apwm_spk (
	input wire logic clk_i,
	input wire apwm_pkg::apwm_pins_type pins_i,
	input wire logic clr_i,
	output logic [15:0] cnt_one_o,
	output logic [15:0] cnt_two_o
);
	import apwm_pkg::*;
	always_ff @(posedge clk_i) begin
		if (clr_i) begin
			cnt_one_o <= 16'h0000;
			cnt_two_o <= 16'h0000;
		end else begin
			cnt_one_o <= cnt_one_o + {15'h0000, pins_i.out_one};
			cnt_two_o <= cnt_two_o + {15'h0000, pins_i.out_two};
		end
	end
endmodule

/* apwm_player_chk.sv */
`timescale 1ns/10ps

// bus and stream timing seen from the pins only
module apwm_player_chk (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic pcm_ready_o,
	input wire apwm_pkg::apwm_pins_type pwm_o,
	input wire logic irq_o
);
	import apwm_pkg::*;
	logic wr_sh;
	// writes to shadowed registers hold off the sample stream
	assign wr_sh = wb_cyc_i && wb_stb_i && wb_we_i && (wb_adr_i inside {8'h08, 8'h0c, 8'h10});
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_take: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("no ack after request");
	a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o))
		else $error("ack without request");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && !irq_o && pwm_o == 2'b00)
		else $error("outputs active after reset");
	a_hole_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h20 |-> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	a_read_narrow: assert property (wb_ack_o && !wb_we_i && wb_adr_i != 8'h14 |->
		wb_dat_o[31:10] == 22'h0)
		else $error("read data above bit 9");
	a_ready_cause: assert property (!pcm_ready_o |-> wr_sh)
		else $error("ready low without shadow write");
	a_ready_high: assert property (!wr_sh |-> pcm_ready_o)
		else $error("ready low while idle");
endmodule

bind apwm_player apwm_player_chk chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .pcm_ready_o(pcm_ready_o), .pwm_o(pwm_o), .irq_o(irq_o));

/* audio_pwm_pcm_player_tb.sv */
`timescale 1ns/10ps
`include "apwm_defs.svh"

module audio_pwm_pcm_player_tb;
	import apwm_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic we = 1'b0;
	logic vld = 1'b0;
	logic clr = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wd = 32'h0;
	logic [15:0] pcm = 16'h0;
	logic [31:0] rd, dat;
	logic [15:0] c1, c2;
	logic ack, rdy, irq;
	apwm_pins_type pins;
	int err_total = 0;
	int num_checks = 0;
	integer seed = 32'h87ae4988;
	// bench clock
	always #12.5 clk_i = ~clk_i;
	apwm_player DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(dat),
		.wb_ack_o(ack), .pcm_data_i(pcm), .pcm_valid_i(vld), .pcm_ready_o(rdy),
		.pwm_o(pins), .irq_o(irq));
	apwm_spk spk (.clk_i(clk_i), .pins_i(pins), .clr_i(clr), .cnt_one_o(c1), .cnt_two_o(c2));
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// one classic cycle, held until one clock past the ack, then a gap cycle
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wd <= d;
		do begin
			@(posedge clk_i);
			#1 n++;
		end while (ack !== 1'b1 && n < 20);
		rd = dat;
		if (ack !== 1'b1) begin
			err_total++;
			complete_run;
		end
		@(posedge clk_i);
		cyc <= 1'b0;
		wd <= ~d;
		@(posedge clk_i);
	endtask
	task automatic send(input logic [15:0] s);
		logic ok;
		int n;
		n = 0;
		pcm <= s;
		vld <= 1'b1;
		do begin
			#1 ok = rdy;
			@(posedge clk_i);
			n++;
		end while (ok !== 1'b1 && n < 20);
		vld <= 1'b0;
		pcm <= ~s;
		if (ok !== 1'b1) begin
			err_total++;
			complete_run;
		end
	endtask
	// duty as cycles high over one whole period window
	task automatic meas(input int dv, input logic [15:0] e);
		clr <= 1'b1;
		@(posedge clk_i);
		clr <= 1'b0;
		repeat (256 * dv) @(posedge clk_i);
		#1 chk("out_one", e[15:8] * dv, {16'h0, c1});
		chk("out_two", e[7:0] * dv, {16'h0, c2});
		@(posedge clk_i);
	endtask
	function automatic logic [15:0] conv(input logic [15:0] s, input logic one);
		if (!one) return {s[15:8], ~s[15:8]};
		if (s[15]) return {s[14:7], 8'h00};
		return {8'h00, ~s[14:7]};
	endfunction
	initial begin
		logic [15:0] s;
		logic [7:0] c0;
		int dv;
		logic [15:0] e;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		// reset contents, with the hole after the counter
		for (int a = 0; a <= 36; a += 4) begin
			wb(1'b0, 8'(a), 32'h0);
			chk("rst_read", 32'h0, rd);
		end
		wb(1'b1, `APWM_ADDR_CTRL0, 32'h11);
		wb(1'b1, `APWM_ADDR_CTRL1, 32'ha9);
		wb(1'b0, `APWM_ADDR_CTRL1, 32'h0);
		chk("ctrl1", 32'ha8, rd);
		wb(1'b1, `APWM_ADDR_PERIOD, 32'h100);
		wb(1'b0, `APWM_ADDR_PERIOD, 32'h0);
		chk("period", 32'h100, rd);
		// clock codes 001, 000 and 101 and both styles, run set last
		for (int m = 0; m < 4; m++) begin
			dv = (m == 2) ? 4 : 1;
			c0 = m == 0 ? 8'h19 : m == 1 ? 8'h1b : m == 2 ? 8'h09 : 8'h59;
			wb(1'b1, `APWM_ADDR_CTRL0, {24'h0, c0});
			for (int i = 0; i < 6; i++) begin
				s = i == 0 ? 16'h4000 : i == 1 ? 16'hc000 : i == 2 ? 16'h0000 : 16'hffff;
				if (i > 3) s = 16'($random(seed));
				send(s);
				e = conv(s, m == 1);
				wb(1'b0, `APWM_ADDR_SAMPLE, 32'h0);
				chk("sample", {16'h0, s}, rd);
				wb(1'b0, `APWM_ADDR_DUTY1, 32'h0);
				chk("duty_one", {24'h0, e[15:8]}, rd);
				wb(1'b0, `APWM_ADDR_DUTY2, 32'h0);
				chk("duty_two", {24'h0, e[7:0]}, rd);
				repeat (520 * dv) @(posedge clk_i);
				meas(dv, e);
			end
		end
		// period event: masked, raised, cleared once stopped
		wb(1'b0, `APWM_ADDR_STATUS, 32'h0);
		chk("st_period", 32'h1, rd & 32'h1);
		chk("irq_masked", 32'h0, {31'h0, irq});
		wb(1'b1, `APWM_ADDR_MASK, 32'h1);
		chk("irq_raised", 32'h1, {31'h0, irq});
		wb(1'b1, `APWM_ADDR_CTRL0, 32'h11);
		wb(1'b1, `APWM_ADDR_STATUS, 32'h7);
		wb(1'b0, `APWM_ADDR_STATUS, 32'h0);
		chk("st_clear", 32'h0, rd & 32'h7);
		chk("irq_clear", 32'h0, {31'h0, irq});
		complete_run;
	end
	// hang guard
	initial begin
		repeat (90000) @(posedge clk_i);
		err_total++;
		complete_run;
	end
endmodule
